// [core/lnb_ctrl_pkg.sv]
/*
 package for the supply-controller serial slave: register field positions,
 bus address, overload timing counts, carrier structs and state encodings.
 assumes a 250 MHz system clock.
*/
package lnb_ctrl_pkg;
   localparam int CLK_MHZ = 250;
   localparam int OL_OFF_TIME_MS = 900;
   localparam int OL_ON_DIVISOR = 10;
   localparam int OL_OFF_CYC = OL_OFF_TIME_MS * 1000 * CLK_MHZ;
   localparam int OL_ON_CYC = OL_OFF_CYC / OL_ON_DIVISOR;
   localparam int OL_CNT_W = 28;
   localparam int STRAP_W = 2;
   localparam logic [6:0] BUS_ADDR_BASE = 7'h08;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [7:0] SYSREG_RESET = 8'h00;
   localparam int F_CL_STATIC = 7;
   localparam int F_TX_SEL = 6;
   localparam int F_TONE = 5;
   localparam int F_BOOST = 4;
   localparam int F_HV_SEL = 3;
   localparam int F_PWR_EN = 2;
   localparam int F_OT_FLAG = 1;
   localparam int F_OL_FLAG = 0;

   // writable upper six bits of the system register
   typedef struct packed {
      logic current_limit_static_sel;
      logic transmit_output_select;
      logic forced_tone_on;
      logic line_loss_boost;
      logic high_voltage_select;
      logic power_enable;
   } ctrl_t;

   // commands to the analog supply blocks
   typedef struct packed {
      logic power_on;
      logic [1:0] level_sel;
      logic tone_on;
      logic transmit_side_output;
      logic receive_side_output;
      logic static_clamp;
   } supply_t;

   typedef enum logic [6:0] {
      L_IDLE = 7'h01,
      L_ADDR = 7'h02,
      L_ADDR_ACK = 7'h04,
      L_WR = 7'h08,
      L_WR_ACK = 7'h10,
      L_RD = 7'h20,
      L_RD_ACK = 7'h40
   } link_state_t;

   typedef enum logic [2:0] {
      OL_IDLE = 3'h1,
      OL_OFF = 3'h2,
      OL_ON = 3'h4
   } ol_state_t;
endpackage

// [core/lnb_control_i2c_slave.sv]
/*
 serial two-wire slave holding the one-byte system register of one supply
 section, plus the control decode and pulsed overload timer it steers.
 assumes scl/sda, strap, sense and lockout pins are asynchronous; the link
 logic runs on link_clk_in, which must be several times faster than scl.
*/
module lnb_control_i2c_slave
#(
   parameter logic [27:0] OL_OFF_HOLD = 28'(lnb_ctrl_pkg::OL_OFF_CYC),
   parameter logic [27:0] OL_ON_HOLD = 28'(lnb_ctrl_pkg::OL_ON_CYC)
)
(
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic link_clk_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic [lnb_ctrl_pkg::STRAP_W-1:0] addr_strap_in,
   input wire logic uvlo_active_in,
   input wire logic overload_detect_in,
   input wire logic over_temp_in,
   input wire logic tone_gate_input_in,
   output lnb_ctrl_pkg::supply_t supply_ctrl_out,
   output logic [7:0] system_control_status_out
);
   import lnb_ctrl_pkg::*;

   // link domain: reset and pin synchronisers
   logic link_rst_q1, link_rst_b;
   logic scl_q1, scl_q2, scl_q3, sda_q1, sda_q2, sda_q3;
   logic uvlo_l_q1, uvlo_l_q2;
   logic [STRAP_W-1:0] strap_q1, strap_q2;
   logic snap_tgl_q1, snap_tgl_q2, snap_tgl_q3;
   logic scl_rise, scl_fall, start_ev, stop_ev, addr_match, byte_end, wr_done;
   link_state_t lst_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r, snap_l_r, wr_data_r;
   logic rw_r, mack_r, sda_oe_r, wr_tgl_r, snap_ack_r;
   // system domain
   logic wr_tgl_q1, wr_tgl_q2, wr_tgl_q3, snap_ack_q1, snap_ack_q2;
   logic ol_q1, ol_q2, ot_q1, ot_q2, tone_q1, tone_q2, uvlo_s_q1, uvlo_s_q2;
   ctrl_t ctrl_r;
   logic ot_flag_r, ol_flag_r, snap_tgl_r;
   logic [7:0] snap_s_r, sysreg_val;
   ol_state_t ol_st_r;
   logic [OL_CNT_W-1:0] ol_cnt_r;
   supply_t supply_r;
   logic sda_low_r;

   always_ff @(posedge link_clk_in)
   begin
      link_rst_q1 <= rst_b_in;
      link_rst_b <= link_rst_q1;
      scl_q1 <= scl_in;
      scl_q2 <= scl_q1;
      scl_q3 <= scl_q2;
      sda_q1 <= sda_in;
      sda_q2 <= sda_q1;
      sda_q3 <= sda_q2;
      uvlo_l_q1 <= uvlo_active_in;
      uvlo_l_q2 <= uvlo_l_q1;
      strap_q1 <= addr_strap_in;
      strap_q2 <= strap_q1;
      snap_tgl_q1 <= snap_tgl_r;
      snap_tgl_q2 <= snap_tgl_q1;
      snap_tgl_q3 <= snap_tgl_q2;
   end

   assign scl_rise = scl_q2 & ~scl_q3;
   assign scl_fall = ~scl_q2 & scl_q3;
   assign start_ev = scl_q2 & scl_q3 & sda_q3 & ~sda_q2;
   assign stop_ev = scl_q2 & scl_q3 & ~sda_q3 & sda_q2;
   assign addr_match = shift_r[7:1] == {BUS_ADDR_BASE[6:STRAP_W], strap_q2};
   assign byte_end = scl_fall && bit_cnt_r == BITS_PER_BYTE;
   assign wr_done = lst_r == L_WR && byte_end && !uvlo_l_q2;

   // link state machine; outputs change only after scl has fallen, or on a start or stop while scl is high
   always_ff @(posedge link_clk_in)
   begin
      if (!link_rst_b)
      begin
         lst_r <= L_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         rw_r <= 1'b0;
         mack_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end
      else if (start_ev)
      begin
         lst_r <= L_ADDR;
         bit_cnt_r <= 4'h0;
         sda_oe_r <= 1'b0;
      end
      else if (stop_ev)
      begin
         lst_r <= L_IDLE;
         sda_oe_r <= 1'b0;
      end
      else
      begin
         unique case (lst_r)
            L_IDLE:
            begin
               bit_cnt_r <= 4'h0;
            end
            L_ADDR, L_WR:
            begin
               if (scl_rise)
               begin
                  shift_r <= {shift_r[6:0], sda_q2};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end
               else if (byte_end)
               begin
                  bit_cnt_r <= 4'h0;
                  if (uvlo_l_q2 || (lst_r == L_ADDR && !addr_match))
                     lst_r <= L_IDLE;
                  else if (lst_r == L_ADDR)
                  begin
                     sda_oe_r <= 1'b1;
                     rw_r <= shift_r[0];
                     lst_r <= L_ADDR_ACK;
                  end
                  else
                  begin
                     sda_oe_r <= 1'b1;
                     lst_r <= L_WR_ACK;
                  end
               end
            end
            L_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  if (rw_r)
                  begin
                     lst_r <= L_RD;
                     shift_r <= snap_l_r;
                     sda_oe_r <= ~snap_l_r[7];
                  end
                  else
                  begin
                     lst_r <= L_WR;
                     sda_oe_r <= 1'b0;
                  end
               end
            end
            L_WR_ACK:
            begin
               if (scl_fall)
               begin
                  lst_r <= L_WR;
                  sda_oe_r <= 1'b0;
               end
            end
            L_RD:
            begin
               if (scl_rise)
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               else if (byte_end)
               begin
                  bit_cnt_r <= 4'h0;
                  sda_oe_r <= 1'b0;
                  lst_r <= L_RD_ACK;
               end
               else if (scl_fall)
               begin
                  shift_r <= {shift_r[6:0], 1'b0};
                  sda_oe_r <= ~shift_r[6];
               end
            end
            L_RD_ACK:
            begin
               if (scl_rise)
                  mack_r <= ~sda_q2;
               else if (scl_fall)
               begin
                  if (mack_r)
                  begin
                     lst_r <= L_RD;
                     shift_r <= snap_l_r;
                     sda_oe_r <= ~snap_l_r[7];
                  end
                  else
                     lst_r <= L_IDLE;
               end
            end
         endcase
      end
   end

   // completed write byte handed to the system domain by toggle
   always_ff @(posedge link_clk_in)
   begin
      if (!link_rst_b)
      begin
         wr_data_r <= 8'h00;
         wr_tgl_r <= 1'b0;
      end
      else if (wr_done)
      begin
         wr_data_r <= shift_r;
         wr_tgl_r <= ~wr_tgl_r;
      end
   end

   // register snapshot taken from the system domain
   always_ff @(posedge link_clk_in)
   begin
      if (!link_rst_b)
      begin
         snap_l_r <= SYSREG_RESET;
         snap_ack_r <= 1'b0;
      end
      else if (snap_tgl_q2 != snap_tgl_q3)
      begin
         snap_l_r <= snap_s_r;
         snap_ack_r <= snap_tgl_q2;
      end
   end

   // open-drain data pin: only ever pulls low
   always_ff @(posedge link_clk_in)
   begin
      if (!link_rst_b)
         sda_low_r <= 1'b0;
      else
         sda_low_r <= 1'b0;
   end
   assign sda_out = sda_low_r;
   assign sda_oe_out = sda_oe_r;

   // system domain synchronisers
   always_ff @(posedge ref_clk_in)
   begin
      wr_tgl_q1 <= wr_tgl_r;
      wr_tgl_q2 <= wr_tgl_q1;
      wr_tgl_q3 <= wr_tgl_q2;
      snap_ack_q1 <= snap_ack_r;
      snap_ack_q2 <= snap_ack_q1;
      ol_q1 <= overload_detect_in;
      ol_q2 <= ol_q1;
      ot_q1 <= over_temp_in;
      ot_q2 <= ot_q1;
      tone_q1 <= tone_gate_input_in;
      tone_q2 <= tone_q1;
      uvlo_s_q1 <= uvlo_active_in;
      uvlo_s_q2 <= uvlo_s_q1;
   end

   // writable control bits
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in || uvlo_s_q2)
         ctrl_r <= ctrl_t'(SYSREG_RESET[7:F_PWR_EN]);
      else if (wr_tgl_q2 != wr_tgl_q3)
         ctrl_r <= ctrl_t'(wr_data_r[7:F_PWR_EN]);
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
         ot_flag_r <= 1'b0;
      else
         ot_flag_r <= ot_q2;
   end

   // overload protection: static clamp or pulsed off/on cycling
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in || !ctrl_r.power_enable)
      begin
         ol_st_r <= OL_IDLE;
         ol_cnt_r <= '0;
         ol_flag_r <= 1'b0;
      end
      else if (ctrl_r.current_limit_static_sel)
      begin
         ol_st_r <= OL_IDLE;
         ol_cnt_r <= '0;
         ol_flag_r <= ol_q2;
      end
      else
      begin
         unique case (ol_st_r)
            OL_IDLE:
            begin
               if (ol_q2)
               begin
                  ol_st_r <= OL_OFF;
                  ol_flag_r <= 1'b1;
               end
               ol_cnt_r <= '0;
            end
            OL_OFF:
            begin
               if (ol_cnt_r == OL_OFF_HOLD - 28'h1)
               begin
                  ol_st_r <= OL_ON;
                  ol_cnt_r <= '0;
               end
               else
                  ol_cnt_r <= ol_cnt_r + 28'h1;
            end
            OL_ON:
            begin
               if (ol_q2)
               begin
                  ol_st_r <= OL_OFF;
                  ol_cnt_r <= '0;
               end
               else if (ol_cnt_r == OL_ON_HOLD - 28'h1)
               begin
                  ol_st_r <= OL_IDLE;
                  ol_flag_r <= 1'b0;
                  ol_cnt_r <= '0;
               end
               else
                  ol_cnt_r <= ol_cnt_r + 28'h1;
            end
         endcase
      end
   end

   assign sysreg_val = {ctrl_r, ot_flag_r, ol_flag_r};

   // publish a new snapshot once the previous one is acknowledged
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
      begin
         snap_s_r <= SYSREG_RESET;
         snap_tgl_r <= 1'b0;
      end
      else if (snap_ack_q2 == snap_tgl_r && snap_s_r != sysreg_val)
      begin
         snap_s_r <= sysreg_val;
         snap_tgl_r <= ~snap_tgl_r;
      end
   end

   // supply block commands
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_b_in)
         supply_r <= '0;
      else
      begin
         supply_r.power_on <= ctrl_r.power_enable && !ot_q2 && ol_st_r != OL_OFF;
         supply_r.level_sel <= {ctrl_r.line_loss_boost, ctrl_r.high_voltage_select};
         supply_r.tone_on <= ctrl_r.power_enable && (ctrl_r.forced_tone_on || tone_q2);
         supply_r.transmit_side_output <= ctrl_r.power_enable && ctrl_r.transmit_output_select;
         supply_r.receive_side_output <= ctrl_r.power_enable && !ctrl_r.transmit_output_select;
         supply_r.static_clamp <= ctrl_r.current_limit_static_sel;
      end
   end
   assign supply_ctrl_out = supply_r;
   assign system_control_status_out = snap_s_r;

   // link domain checks
   a_no_ack_lockout: assert property (@(posedge link_clk_in) disable iff (!link_rst_b)
      (lst_r inside {L_ADDR, L_WR}) && byte_end && uvlo_l_q2 && !start_ev && !stop_ev
      |=> !sda_oe_r && lst_r == L_IDLE)
      else $error("acknowledge given during lockout");
   a_ack_held_low: assert property (@(posedge link_clk_in) disable iff (!link_rst_b)
      (lst_r inside {L_ADDR_ACK, L_WR_ACK}) |-> sda_oe_r)
      else $error("acknowledge released early");
   a_sda_scl_high: assert property (@(posedge link_clk_in) disable iff (!link_rst_b)
      scl_q2 && scl_q3 && !stop_ev && !start_ev |=> $stable(sda_oe_r) || !scl_q3)
      else $error("sda changed while scl high");
   a_start_addr: assert property (@(posedge link_clk_in) disable iff (!link_rst_b)
      start_ev |=> lst_r == L_ADDR && bit_cnt_r == 4'h0)
      else $error("start not taken");
   a_stop_idle: assert property (@(posedge link_clk_in) disable iff (!link_rst_b)
      stop_ev && !start_ev |=> lst_r == L_IDLE && !sda_oe_r)
      else $error("stop not taken");
   a_read_msb: assert property (@(posedge link_clk_in) disable iff (!link_rst_b)
      lst_r == L_ADDR_ACK && scl_fall && rw_r && !start_ev && !stop_ev
      |=> sda_oe_r == !$past(snap_l_r[7]))
      else $error("read does not start with msb");
   a_addr_miss: assert property (@(posedge link_clk_in) disable iff (!link_rst_b)
      lst_r == L_ADDR && byte_end && !addr_match |=> lst_r == L_IDLE && !sda_oe_r)
      else $error("foreign address acknowledged");
   a_write_ack: assert property (@(posedge link_clk_in) disable iff (!link_rst_b)
      wr_done |=> lst_r == L_WR_ACK && sda_oe_r ##1 wr_tgl_r == !$past(wr_tgl_r, 2))
      else $error("write byte not acknowledged");
   a_read_nack_end: assert property (@(posedge link_clk_in) disable iff (!link_rst_b)
      lst_r == L_RD_ACK && scl_fall && !mack_r && !stop_ev |=> lst_r == L_IDLE)
      else $error("read continued after nack");
   // system domain checks
   a_write_upper: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      wr_tgl_q2 != wr_tgl_q3 && !uvlo_s_q2 |=> ctrl_r == ctrl_t'($past(wr_data_r[7:2])))
      else $error("write not loaded into control bits");
   a_lockout_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      uvlo_s_q2 |=> ctrl_r == ctrl_t'(6'h00))
      else $error("register not cleared in lockout");
   a_pulsed_off: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      ol_st_r == OL_OFF && ctrl_r.power_enable && !ctrl_r.current_limit_static_sel
      |=> !supply_r.power_on && ol_flag_r)
      else $error("output on during overload off time");
   a_standby_off: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      !ctrl_r.power_enable |=> !supply_r.power_on && !supply_r.tone_on
      && !supply_r.transmit_side_output && !supply_r.receive_side_output)
      else $error("power block active in standby");
   a_static_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      ctrl_r.power_enable && ctrl_r.current_limit_static_sel ##1
      ctrl_r.power_enable && ctrl_r.current_limit_static_sel |-> ol_flag_r == $past(ol_q2))
      else $error("static flag does not follow clamp");

   c_read_more: cover property (@(posedge link_clk_in) disable iff (!link_rst_b)
      lst_r == L_RD_ACK && mack_r && scl_fall);
   c_write_byte: cover property (@(posedge link_clk_in) disable iff (!link_rst_b) wr_done);
   c_pulsed_cycle: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in)
      ol_st_r == OL_ON ##1 ol_st_r == OL_IDLE);
endmodule // lnb_control_i2c_slave

// [verification/i2c_master_model.sv]
/*
 behavioural bus master for the supply-controller slave: start, stop, byte write
 and byte read over an open-drain data line.
 assumes the bench resolves sda with a pull-up and clocks this model at ref rate.
*/
module i2c_master_model
(
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_pull_out
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = 40;

   initial
   begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // called only from idle after a stop: sda falls while scl high
   task automatic start_bit;
      sda_pull_out <= 1'b1;
      wait_clk(HALF);
      scl_out <= 1'b0;
   endtask

   // sda rises while scl high, bus left idle
   task automatic stop_bit;
      wait_clk(HALF / 4);
      sda_pull_out <= 1'b1;
      wait_clk(HALF);
      scl_out <= 1'b1;
      wait_clk(HALF);
      sda_pull_out <= 1'b0;
      wait_clk(HALF);
   endtask

   // data changes only while scl low, sampled mid high phase
   task automatic clock_bit(input logic b, output logic s);
      wait_clk(HALF / 4);
      sda_pull_out <= ~b;
      wait_clk(HALF);
      scl_out <= 1'b1;
      wait_clk(HALF / 2);
      s = sda_in;
      wait_clk(HALF / 2);
      scl_out <= 1'b0;
   endtask

   // eight bits msb first, then line released for the acknowledge slot
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clock_bit(d[i], s);
      clock_bit(1'b1, s);
      ack = ~s;
   endtask

   // acknowledge asks for another byte, no acknowledge on the last one
   task automatic read_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         clock_bit(1'b1, s);
         d[i] = s;
      end
      clock_bit(last, s);
   endtask
endmodule // i2c_master_model

// [verification/tb_top.sv]
/*
 self-checking bench for the supply-controller serial slave: register writes and
 reads over the two-wire bus, address strap, lockout, overload and temperature flags.
 assumes shortened overload hold counts and a pull-up on sda.
*/
`define CHK(nm, got, exp) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("ERROR %s expected %h seen %h", nm, exp, got); \
      end \
   end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import lnb_ctrl_pkg::*;

   logic ref_clk, link_clk, rst_b, scl, sda_pull, sda_oe;
   logic uvlo, overload, over_temp, tone_gate, k_a, k_d, sda_lvl;
   logic [1:0] strap;
   logic [7:0] status, rd0, rd1;
   supply_t supply;
   wire sda;
   int mismatches, cmp_count;
   logic [7:0] tbl [8] = '{8'hff, 8'h07, 8'h0c, 8'h14, 8'h1c, 8'h25, 8'h46, 8'hfb};

   assign sda = ~(sda_pull | sda_oe);

   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   initial
   begin
      link_clk = 1'b0;
      #1.3;
      forever #7.5 link_clk = ~link_clk;
   end

   lnb_control_i2c_slave #(.OL_OFF_HOLD(28'h64), .OL_ON_HOLD(28'ha)) uut
   (
      .ref_clk_in(ref_clk),
      .rst_b_in(rst_b),
      .link_clk_in(link_clk),
      .scl_in(scl),
      .sda_in(sda),
      .sda_out(sda_lvl),
      .sda_oe_out(sda_oe),
      .addr_strap_in(strap),
      .uvlo_active_in(uvlo),
      .overload_detect_in(overload),
      .over_temp_in(over_temp),
      .tone_gate_input_in(tone_gate),
      .supply_ctrl_out(supply),
      .system_control_status_out(status)
   );

   i2c_master_model m
   (
      .clk_in(ref_clk),
      .sda_in(sda),
      .scl_out(scl),
      .sda_pull_out(sda_pull)
   );

   function automatic logic [6:0] exp_sup(input logic [7:0] r, input logic g);
      logic p;
      p = r[F_PWR_EN];
      return {p, r[F_BOOST], r[F_HV_SEL], p & (r[F_TONE] | g), p & r[F_TX_SEL],
         p & ~r[F_TX_SEL], r[F_CL_STATIC]};
   endfunction

   task automatic settle;
      repeat (30) @(posedge ref_clk);
   endtask

   // data byte sent whatever the address slot showed
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ea);
      m.start_bit();
      m.write_byte(a, k_a);
      m.write_byte(d, k_d);
      m.stop_bit();
      `CHK("address ack", k_a, ea);
      `CHK("data ack", k_d, ea);
      settle();
   endtask

   task automatic rd(input logic [7:0] e);
      m.start_bit();
      m.write_byte(8'h11, k_a);
      m.read_byte(1'b0, rd0);
      m.read_byte(1'b1, rd1);
      m.stop_bit();
      settle();
      `CHK("read address ack", k_a, 1'b1);
      `CHK("read first", rd0, e);
      `CHK("read second", rd1, e);
      `CHK("released", sda_oe, 1'b0);
   endtask

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      rst_b = 1'b0;
      strap = 2'h0;
      uvlo = 1'b0;
      overload = 1'b0;
      over_temp = 1'b0;
      tone_gate = 1'b0;
      mismatches = 0;
      cmp_count = 0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      settle();
      `CHK("reset status", status, 8'h00);
      `CHK("reset supply", supply, 7'h00);
      `CHK("reset oe", sda_oe, 1'b0);
      `CHK("drive level", sda_lvl, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
         tone_gate <= i[0];
         wr(8'h10, tbl[i], 1'b1);
         `CHK("status", status, {tbl[i][7:2], 2'h0});
         `CHK("supply", supply, exp_sup(tbl[i], i[0]));
      end
      rd(8'hf8);
      wr(8'h12, 8'h00, 1'b0);
      `CHK("foreign address", status, 8'hf8);
      strap <= 2'h1;
      wr(8'h12, 8'h9c, 1'b1);
      `CHK("strap address", status, 8'h9c);
      strap <= 2'h0;
      uvlo <= 1'b1;
      settle();
      `CHK("lockout clear", status, 8'h00);
      wr(8'h10, 8'h04, 1'b0);
      `CHK("lockout write", status, 8'h00);
      uvlo <= 1'b0;
      settle();
      wr(8'h10, 8'h04, 1'b1);
      overload <= 1'b1;
      repeat (20) @(posedge ref_clk);
      `CHK("pulsed flag", status[F_OL_FLAG], 1'b1);
      `CHK("pulsed off", supply.power_on, 1'b0);
      overload <= 1'b0;
      repeat (150) @(posedge ref_clk);
      `CHK("pulsed clear", status, 8'h04);
      `CHK("pulsed on", supply.power_on, 1'b1);
      wr(8'h10, 8'h84, 1'b1);
      overload <= 1'b1;
      settle();
      `CHK("static flag", status, 8'h85);
      overload <= 1'b0;
      settle();
      `CHK("static clear", status, 8'h84);
      over_temp <= 1'b1;
      settle();
      `CHK("temp flag", status, 8'h86);
      over_temp <= 1'b0;
      settle();
      `CHK("temp clear", status, 8'h84);
      `CHK("final drive level", sda_lvl, 1'b0);
      close_out();
   end

   initial
   begin
      repeat (100000) @(posedge ref_clk);
      mismatches++;
      close_out();
   end
endmodule // tb_top
